// ==== inc/odsl_pkg.sv ====
// Package for the octal serial DAC loader: word layout, codes, timing.
// Assumes a 10 MHz system clock sampling the serial pins.
package odsl_pkg;
  localparam int          ODSL_WORD_BITS    = 11;
  localparam int          ODSL_CODE_BITS    = 8;
  localparam int          ODSL_ADDR_BITS    = 3;
  localparam int          ODSL_CHANNELS     = 8;
  localparam int          ODSL_ADDR_MSB     = 10;
  localparam int          ODSL_ADDR_LSB     = 8;
  localparam int          ODSL_CODE_MSB     = 7;
  localparam int          ODSL_CODE_LSB     = 0;
  localparam logic [7:0]  ODSL_MIDSCALE     = 8'h80;
  localparam logic [10:0] ODSL_SHIFT_RESET  = 11'h000;
  localparam int          ODSL_FULL_SPAN    = 256;
  localparam int          ODSL_CLK_HZ       = 10_000_000;
  localparam int          ODSL_SCLK_MAX_HZ  = 33_000_000;
  localparam int          ODSL_SYNC_STAGES  = 3;
endpackage

// ==== rtl/odsl_pin_sync.sv ====
// Three-stage synchroniser for one pin, with agreed-level output.
// Assumes the pin is asynchronous to clk; stage one feeds stage two only.
`timescale 1ns/10ps
`default_nettype none
module odsl_pin_sync
  import odsl_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic clk_en,
  // Pin and result
  input  wire logic pin,
  output logic      level
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_q;
  logic       level_d;

  always_comb begin
    stage_d = {stage_q[1:0], pin};
    level_d = level_q;
    // A change counts only once the last two stages agree.
    if (stage_q[2] == stage_q[1]) begin
      level_d = stage_q[2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage_q <= {3{RESET_LEVEL}};
      level_q <= RESET_LEVEL;
    end else if (clk_en) begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule
`default_nettype wire

// ==== rtl/odsl_loader.sv ====
// Contract
// - Word is 3 address then 8 code bits, MSB first.
// - Bits 10..8 address, bits 7..0 code.
// - Channel number is address plus one.
// - Chip select low: rising clock shifts one bit.
// - Chip select rise loads selected latch.
// - Only last 11 bits are kept.
// - Exactly one latch clocked per transfer.
// - Other seven latches stay unchanged.
// - Serial clock at most 33 MHz.
// - Preset loads every latch with 128.
// - Shutdown keeps all latch codes.
// - Shutdown deasserts all output enables.
// - Release restores outputs from held codes.
// - Output equals code over 256 of span.
// - Preset is active low, independent of serial clock.
// - Shutdown is active low, keeps latches.
//
// Octal 8-bit DAC serial loader: shift register, decoder, eight latches.
// Assumes all serial and control pins are asynchronous to clk and that the
// serial clock is far slower than clk; the 33 MHz pin rate cannot be
// oversampled at 10 MHz, so the bench must slow the link clock.
`timescale 1ns/10ps
`default_nettype none
module odsl_loader
  import odsl_pkg::*;
#(
  parameter int WORD_BITS = ODSL_WORD_BITS,
  parameter int CHANNELS  = ODSL_CHANNELS
) (
  // Clock, reset and enable
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic clk_en,
  // Serial port pins
  input  wire logic chip_sel_n,
  input  wire logic serial_clk,
  input  wire logic serial_in,
  // Control pins
  input  wire logic midscale_preset_n,
  input  wire logic power_down_n,
  // Channel codes and output enables
  output logic [CHANNELS*ODSL_CODE_BITS-1:0] channel_latch,
  output logic [CHANNELS-1:0]                analog_out_en,
  output logic                               ref_en
);
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic preset_n_s;
  logic pwr_n_s;

  // Every pin is asynchronous to clk and passes three stages. Chip select
  // and the link clock rest high, so their stages reset high as well.
  // Shutdown and preset reset inactive, so reset never fakes a preset or a shutdown.
  odsl_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (
    .clk    (clk),
    .srst   (srst),
    .clk_en (clk_en),
    .pin    (chip_sel_n),
    .level  (cs_n_s)
  );
  odsl_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_sclk (
    .clk    (clk),
    .srst   (srst),
    .clk_en (clk_en),
    .pin    (serial_clk),
    .level  (sclk_s)
  );
  odsl_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sdi (
    .clk    (clk),
    .srst   (srst),
    .clk_en (clk_en),
    .pin    (serial_in),
    .level  (sdi_s)
  );
  odsl_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_rs (
    .clk    (clk),
    .srst   (srst),
    .clk_en (clk_en),
    .pin    (midscale_preset_n),
    .level  (preset_n_s)
  );
  odsl_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_pd (
    .clk    (clk),
    .srst   (srst),
    .clk_en (clk_en),
    .pin    (power_down_n),
    .level  (pwr_n_s)
  );

  // Channel index is the address; the channel number is one higher.
  function automatic logic [CHANNELS-1:0] odsl_decode(
    input logic [ODSL_ADDR_BITS-1:0] addr
  );
    logic [CHANNELS-1:0] onehot;
    // An address beyond the channel count selects nothing.
    for (int c = 0; c < CHANNELS; c++) begin
      onehot[c] = (c == int'(addr));
    end
    return onehot;
  endfunction

  // True for one cycle when a synchronised level goes from low to high.
  function automatic logic odsl_rose(
    input logic now_level,
    input logic was_level
  );
    return now_level & ~was_level;
  endfunction

  logic [WORD_BITS-1:0]      shift_q;
  logic [WORD_BITS-1:0]      shift_d;
  logic                      sclk_prev_q;
  logic                      sclk_prev_d;
  logic                      cs_prev_q;
  logic                      cs_prev_d;
  logic [ODSL_CODE_BITS-1:0] latch_q [CHANNELS];
  logic [ODSL_CODE_BITS-1:0] latch_d [CHANNELS];
  logic [CHANNELS-1:0]       oe_q;
  logic [CHANNELS-1:0]       oe_d;
  logic                      ref_en_q;
  logic                      ref_en_d;
  logic                      sclk_rise;
  logic                      cs_rise;
  logic [CHANNELS-1:0]       load_sel;

  // Edges are found by sampling, so the link clock must stay far below
  // clk; the full 33 MHz pin rate cannot be seen at this sampling rate.
  assign sclk_rise = odsl_rose(sclk_s, sclk_prev_q);
  assign cs_rise   = odsl_rose(cs_n_s, cs_prev_q);
  assign load_sel  = cs_rise ?
    odsl_decode(shift_q[ODSL_ADDR_MSB:ODSL_ADDR_LSB]) : '0;

  // Both edge histories rest high, the idle level of their pins, so that
  // no false edge follows reset.
  always_comb begin
    sclk_prev_d = sclk_s;
    cs_prev_d   = cs_n_s;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
    end else if (clk_en) begin
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q   <= cs_prev_d;
    end
  end

  always_comb begin
    shift_d = shift_q;
    // Edges while deselected are ignored; older bits fall off the top.
    if (!cs_n_s && sclk_rise) begin
      shift_d = {shift_q[WORD_BITS-2:0], sdi_s};
    end
  end

  // A frame shorter than a word leaves stale high bits in place.
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_q <= ODSL_SHIFT_RESET;
    end else if (clk_en) begin
      shift_q <= shift_d;
    end
  end

  // The preset pin is sampled like the rest, so it acts a few clk late.
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      latch_d[i] = latch_q[i];
      // Preset wins over a coincident load, as the async pin would.
      if (!preset_n_s) begin
        latch_d[i] = ODSL_MIDSCALE;
      end else if (load_sel[i]) begin
        latch_d[i] = shift_q[ODSL_CODE_MSB:ODSL_CODE_LSB];
      end
    end
  end

  // Reset gives the same midscale code as the preset pin.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        latch_q[i] <= ODSL_MIDSCALE;
      end
    end else if (clk_en) begin
      for (int i = 0; i < CHANNELS; i++) begin
        latch_q[i] <= latch_d[i];
      end
    end
  end

  // Latches are untouched by shutdown; only enables follow it.
  always_comb begin
    oe_d     = {CHANNELS{pwr_n_s}};
    ref_en_d = pwr_n_s;
  end

  // Enables start low and rise one clk after reset, from the high reset level of the shutdown stage.
  always_ff @(posedge clk) begin
    if (srst) begin
      oe_q     <= '0;
      ref_en_q <= 1'b0;
    end else if (clk_en) begin
      oe_q     <= oe_d;
      ref_en_q <= ref_en_d;
    end
  end

  // Code k maps to k/256 of the reference span in the analog ladder.
  always_comb begin
    channel_latch = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      channel_latch[i*ODSL_CODE_BITS +: ODSL_CODE_BITS] = latch_q[i];
    end
  end
  assign analog_out_en = oe_q;
  assign ref_en        = ref_en_q;
endmodule
`default_nettype wire

// ==== tb/odsl_host_model.sv ====
// Host model driving the three-wire serial port.
// Assumes clk at 100 ns; one bit takes 800 ns.
`timescale 1ns/10ps
`default_nettype none
module odsl_host_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      chip_sel_n,
  output logic      serial_clk,
  output logic      serial_in
);
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b1;
    serial_in  = 1'b0;
  end
  // Data moves only while the clock is low, far below 33 MHz.
  task automatic put(input logic b);
    serial_clk = 1'b0;
    serial_in  = b;
    repeat (4) @(negedge clk);
    serial_clk = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic frame(input logic [10:0] w, input logic [4:0] pre,
                       input logic lng);
    chip_sel_n = 1'b0;
    if (lng)
      for (int i = 4; i >= 0; i--) put(pre[i]);
    for (int i = 10; i >= 0; i--) put(w[i]);
    chip_sel_n = 1'b1;
    serial_in  = ~serial_in;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/odsl_loader_properties.sv ====
// Port checker for the loader.
// Assumes clk_en low only freezes state; pin changes show a few clk later.
`timescale 1ns/10ps
`default_nettype none
module odsl_loader_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Pins
  input wire logic        chip_sel_n,
  input wire logic        midscale_preset_n,
  input wire logic        power_down_n,
  // Outputs
  input wire logic [63:0] channel_latch,
  input wire logic [7:0]  analog_out_en,
  input wire logic        ref_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence idle_s;
    (chip_sel_n && midscale_preset_n) [*8];
  endsequence
  sequence shift_s;
    (!chip_sel_n && midscale_preset_n) [*8];
  endsequence
  idle_hold_a: assert property (idle_s |=> $stable(channel_latch))
    else $error("latch moved while idle");
  shift_hold_a: assert property (shift_s |=> $stable(channel_latch))
    else $error("latch moved while shifting");
  load_rise_a: assert property ($changed(channel_latch) &&
    $past(midscale_preset_n, 5) |-> $past(chip_sel_n))
    else $error("load without select rise");
  preset_mid_a: assert property (!midscale_preset_n [*6]
    |-> channel_latch == {8{8'h80}}) else $error("preset missed");
  power_down_n_out_a: assert property (!power_down_n [*6]
    |-> analog_out_en == 8'h00) else $error("outputs on in shutdown");
  power_down_n_ref_a: assert property (!power_down_n [*6] |-> !ref_en)
    else $error("reference on in shutdown");
  wake_on_a: assert property (power_down_n [*7]
    |-> analog_out_en == 8'hff && ref_en) else $error("outputs off");
  en_group_a: assert property (analog_out_en == {8{ref_en}})
    else $error("enables disagree");
endmodule
bind odsl_loader odsl_loader_properties u_props (.clk(clk), .srst(srst),
  .chip_sel_n(chip_sel_n), .midscale_preset_n(midscale_preset_n),
  .power_down_n(power_down_n), .channel_latch(channel_latch),
  .analog_out_en(analog_out_en), .ref_en(ref_en));
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the octal DAC loader.
// Assumes the host model paces frames itself.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import odsl_pkg::*;
  logic        clk, srst, clk_en, midscale_preset_n, power_down_n;
  logic        chip_sel_n, serial_clk, serial_in, ref_en;
  logic [63:0] channel_latch, exp_q;
  logic [7:0]  analog_out_en;
  int          bad_count = 0, n_compared = 0, cycles = 0;
  odsl_host_model u_odsl_host_model (.clk(clk), .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk), .serial_in(serial_in));
  odsl_loader u_odsl_loader (.clk(clk), .srst(srst), .clk_en(clk_en),
    .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .midscale_preset_n(midscale_preset_n),
    .power_down_n(power_down_n), .channel_latch(channel_latch),
    .analog_out_en(analog_out_en), .ref_en(ref_en));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A hang past the expected run length counts as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic t_each();
    for (int i = 7; i >= 0; i--) begin
      u_odsl_host_model.frame({i[2:0], 8'h1b + 8'(i)}, 5'h00, 1'b0);
      exp_q[8*i +: 8] = 8'h1b + 8'(i);
      chk(channel_latch, exp_q);
    end
    $display("each channel done");
  endtask
  task automatic t_long();
    u_odsl_host_model.frame({3'h4, 8'h00}, 5'h1f, 1'b1);
    exp_q[39:32] = 8'h00;
    chk(channel_latch, exp_q);
    $display("long frame done");
  endtask
  task automatic t_freeze();
    clk_en = 1'b0;
    u_odsl_host_model.frame({3'h2, 8'h5a}, 5'h00, 1'b0);
    chk(channel_latch, exp_q);
    clk_en = 1'b1;
    repeat (8) @(negedge clk);
    chk(channel_latch, exp_q);
    chk(64'({ref_en, analog_out_en}), 64'h1ff);
    $display("freeze done");
  endtask
  task automatic t_power_down_n();
    power_down_n = 1'b0;
    repeat (8) @(negedge clk);
    chk(64'({ref_en, analog_out_en}), 64'h000);
    chk(channel_latch, exp_q);
    power_down_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(64'({ref_en, analog_out_en}), 64'h1ff);
    chk(channel_latch, exp_q);
    $display("shutdown done");
  endtask
  task automatic t_preset();
    midscale_preset_n = 1'b0;
    repeat (8) @(negedge clk);
    exp_q = {8{ODSL_MIDSCALE}};
    chk(channel_latch, exp_q);
    $display("preset done");
  endtask
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    midscale_preset_n = 1'b1;
    power_down_n = 1'b1;
    exp_q = {8{ODSL_MIDSCALE}};
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    chk(channel_latch, exp_q);
    t_each();
    t_freeze();
    t_long();
    t_power_down_n();
    t_preset();
    complete_run();
  end
endmodule
`default_nettype wire
